// ===== include/icache_diag_consts.vh
/*
  Constants for the instruction cache diagnostic data registers: CSR
  addresses, field positions, check-bit widths and reset values.
  Assumes inclusion by bare name from the design files.
*/
`ifndef ICACHE_DIAG_CONSTS_VH
`define ICACHE_DIAG_CONSTS_VH

// ----------------------------------------------------------------------
// CSR addresses
// ----------------------------------------------------------------------
`define CSR_DATA_LOW        12'h7c9
`define CSR_CHECK_BITS      12'h7ca
`define CSR_GO              12'h7cb
`define CSR_DATA_HIGH       12'h7cc

// ----------------------------------------------------------------------
// Field positions of the low data register in tag layout, and the go bit of the go register
// ----------------------------------------------------------------------
`define TAG_LSB             11
`define TAG_MSB             31
`define LRU_LSB             4
`define LRU_MSB             6
`define LRU_PAIR_BIT        4
`define LRU_LOW_BIT         5
`define LRU_HIGH_BIT        6
`define VALID_BIT           0
`define GO_BIT              0

// ----------------------------------------------------------------------
// Check-bit layouts
// ----------------------------------------------------------------------
`define PAR_DATA_BITS       6'h04
`define PAR_TAG_BITS        6'h01
`define ECC_DATA_BITS       6'h07
`define ECC_TAG_BITS        6'h05
`define CHECK_MODE_PARITY   1'b0
`define CHECK_MODE_ECC      1'b1

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define RESET_WORD          32'h0000_0000
`define RESET_LRU           3'h0

`endif

// ===== rtl/check_bits_mask.v
/*
  Mask applied to the check-bit register: keeps only the bits of the
  layout in force for the build and the selected array.
  Assumes a constant build mode and a registered array select.
*/
`timescale 1ns/1ps
`include "icache_diag_consts.vh"

module check_bits_mask
#(
  parameter CHECK_MODE = `CHECK_MODE_PARITY
)
(
  input  wire        tag_sel,
  output wire [31:0] mask
);

  wire [5:0] keep;

  // The number of live low bits, chosen by build and array.
  assign keep = (CHECK_MODE == `CHECK_MODE_ECC)
              ? (tag_sel ? `ECC_TAG_BITS : `ECC_DATA_BITS)
              : (tag_sel ? `PAR_TAG_BITS : `PAR_DATA_BITS);

  genvar i;
  generate
    for (i = 0; i < 32; i = i + 1)
    begin : g_bit
      assign mask[i] = (i < keep);
    end
  endgenerate

endmodule // check_bits_mask

// ===== rtl/icache_diag_data_regs.v
/*
  Debug-mode diagnostic data registers of the instruction cache: the low
  and high data words and the check-bit word, copied to the selected
  array on a go write; a go read loads the check-bit word from either array,
  and both data words from the data array or only the tag, LRU and valid
  fields of the low word from the tag array.
  Assumes a CSR port from the core, array select, way and index from the
  selection register, and an array port that answers reads in one cycle.
*/
`timescale 1ns/1ps
`include "icache_diag_consts.vh"

module icache_diag_data_regs
#(
  parameter CHECK_MODE = `CHECK_MODE_PARITY,
  parameter WAYS       = 4,
  parameter INDEX_W    = 14
)
(
  input  wire               clk,
  input  wire               rstn,
  input  wire               debug_mode,
  input  wire               csr_read,
  input  wire               csr_write,
  input  wire [11:0]        csr_addr,
  input  wire [31:0]        csr_wdata,
  output reg  [31:0]        csr_rdata,
  output wire               csr_hit,
  output wire               illegal_instr,
  input  wire               array_sel,
  input  wire [1:0]         way_sel,
  input  wire [INDEX_W-1:0] index_sel,
  output reg                arr_rd,
  output reg                arr_wr,
  output reg                arr_tag_sel,
  output reg  [1:0]         arr_way,
  output reg  [INDEX_W-1:0] arr_index,
  output wire               arr_bank,
  output reg  [63:0]        arr_wdata,
  output reg  [6:0]         arr_wcheck,
  input  wire [63:0]        arr_rdata,
  input  wire [6:0]         arr_rcheck,
  output wire [1:0]         lru_victim_way
);

  // ----------------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------------
  reg  [31:0] icache_diag_data_low;
  reg  [31:0] icache_diag_data_high;
  reg  [31:0] icache_diag_check_bits;
  reg         load_pending;
  wire [31:0] check_mask;

  check_bits_mask #(
    .CHECK_MODE (CHECK_MODE)
  ) u_mask (
    .tag_sel (array_sel),
    .mask    (check_mask)
  );

  lru_way_decode #(
    .WAYS (WAYS)
  ) u_lru (
    .lru        (icache_diag_data_low[`LRU_MSB:`LRU_LSB]),
    .victim_way (lru_victim_way)
  );

  // ----------------------------------------------------------------------
  // CSR decode
  // ----------------------------------------------------------------------
  wire hit_low   = (csr_addr == `CSR_DATA_LOW);
  wire hit_check = (csr_addr == `CSR_CHECK_BITS);
  wire hit_high  = (csr_addr == `CSR_DATA_HIGH);
  wire hit_go    = (csr_addr == `CSR_GO);
  wire any_hit   = hit_low | hit_check | hit_high | hit_go;
  wire access    = (csr_read | csr_write) & any_hit;
  wire granted   = access & debug_mode;

  assign csr_hit       = any_hit;
  assign illegal_instr = access & ~debug_mode;

  wire go_read  = granted & csr_read & hit_go;
  wire go_write = granted & csr_write & hit_go & csr_wdata[`GO_BIT];

  always @*
  begin
    csr_rdata = `RESET_WORD;
    if (granted & csr_read)
    begin
      if (hit_low)
        csr_rdata = icache_diag_data_low;
      else if (hit_high)
        csr_rdata = icache_diag_data_high;
      else if (hit_check)
        csr_rdata = icache_diag_check_bits & check_mask;
    end
  end

  // Bank is index bit 3; bits 2:0 pick a byte within the 8-byte bank.
  assign arr_bank = arr_index[3];

  // ----------------------------------------------------------------------
  // Registers and array transfers
  // ----------------------------------------------------------------------
  always @(posedge clk)
  begin
    if (!rstn)
    begin
      icache_diag_data_low   <= `RESET_WORD;
      icache_diag_data_high  <= `RESET_WORD;
      icache_diag_check_bits <= `RESET_WORD;
      load_pending           <= 1'b0;
      arr_rd                 <= 1'b0;
      arr_wr                 <= 1'b0;
      arr_tag_sel            <= 1'b0;
      arr_way                <= 2'h0;
      arr_index              <= {INDEX_W{1'b0}};
      arr_wdata              <= 64'h0;
      arr_wcheck             <= 7'h0;
    end
    else
    begin
      arr_rd       <= go_read;
      arr_wr       <= go_write;
      load_pending <= go_read;
      if (go_read | go_write)
      begin
        arr_tag_sel <= array_sel;
        arr_way     <= way_sel;
        arr_index   <= index_sel;
      end
      if (go_write)
      begin
        arr_wdata  <= {icache_diag_data_high, icache_diag_data_low};
        // Software check bits pass, masked to the live layout, so errors can be injected.
        arr_wcheck <= icache_diag_check_bits[6:0] & check_mask[6:0];
      end
      if (granted & csr_write & hit_low)
        icache_diag_data_low <= csr_wdata;
      if (granted & csr_write & hit_high)
        icache_diag_data_high <= csr_wdata;
      if (granted & csr_write & hit_check)
        icache_diag_check_bits <= csr_wdata & check_mask;
      if (load_pending)
      begin
        if (arr_tag_sel)
        begin
          // Tag in place at bits 31:11, set LRU, line valid; bits 10:7, 3:1 kept.
          icache_diag_data_low[`TAG_MSB:`TAG_LSB] <=
            arr_rdata[`TAG_MSB:`TAG_LSB];
          icache_diag_data_low[`LRU_MSB:`LRU_LSB] <=
            (WAYS == 2) ? {2'h0, arr_rdata[`LRU_PAIR_BIT]}
                        : arr_rdata[`LRU_MSB:`LRU_LSB];
          icache_diag_data_low[`VALID_BIT] <= arr_rdata[`VALID_BIT];
        end
        else
        begin
          icache_diag_data_low  <= arr_rdata[31:0];
          icache_diag_data_high <= arr_rdata[63:32];
        end
        // Check bits as stored in the array, masked to the live layout.
        icache_diag_check_bits <= {25'h0, arr_rcheck}
                                  & check_mask;
      end
    end
  end

endmodule // icache_diag_data_regs

// ===== rtl/lru_way_decode.v
/*
  Decodes the set's pseudo-LRU bits into the least recently used way.
  Assumes a two-way or four-way cache chosen by parameter.
*/
`timescale 1ns/1ps
`include "icache_diag_consts.vh"

module lru_way_decode
#(
  parameter WAYS = 4
)
(
  input  wire [2:0] lru,
  output wire [1:0] victim_way
)
;
  // Bit 4 picks the pair, bits 5 and 6 pick within each pair.
  assign victim_way = (WAYS == 2) ? {1'b0, lru[0]}
                    : (lru[0] ? {1'b1, lru[2]} : {1'b0, lru[1]});

endmodule // lru_way_decode

// ===== verif/icache_array_model.sv
/* Behavioural data and tag array behind the diagnostic registers.
   Assumes requests held from the go edge; answers while arr_rd is high. */
`timescale 1ns/1ps
module icache_array_model
(
  input  wire        clk,
  input  wire        arr_rd,
  input  wire        arr_wr,
  input  wire        arr_tag_sel,
  input  wire [1:0]  arr_way,
  input  wire [13:0] arr_index,
  input  wire [63:0] arr_wdata,
  input  wire [6:0]  arr_wcheck,
  output wire [63:0] arr_rdata,
  output wire [6:0]  arr_rcheck
);
  reg  [70:0] mem [0:31];
  wire [4:0]  slot = {arr_tag_sel, arr_way, arr_index[4:3]};
  wire [70:0] q = mem[slot];
  // Outside a read the answer is inverted so stale data cannot pass.
  assign {arr_rcheck, arr_rdata} = arr_rd ? q : ~q;
  always @(posedge clk)
    if (arr_wr)
      mem[slot] <= {arr_wcheck, arr_wdata};
endmodule // icache_array_model

// ===== verif/icache_diag_data_regs_tb.sv
/* Directed bench for the diagnostic data registers over the CSR port.
   Assumes the array model and the checker are compiled alongside. */
`timescale 1ns/1ps
module icache_diag_data_regs_tb;
  reg         clk = 1'b0;
  reg         rstn = 1'b0;
  reg         debug_mode = 1'b1;
  reg         csr_read = 1'b0;
  reg         csr_write = 1'b0;
  reg  [11:0] csr_addr = 12'h0;
  reg  [31:0] csr_wdata = 32'h0;
  reg         array_sel = 1'b0;
  reg  [1:0]  way_sel = 2'h0;
  reg  [13:0] index_sel = 14'h0;
  reg  [31:0] q;
  reg         ill;
  wire [31:0] csr_rdata;
  wire [63:0] arr_wdata, arr_rdata;
  wire [13:0] arr_index;
  wire [6:0]  arr_wcheck, arr_rcheck;
  wire [1:0]  arr_way, lru_victim_way;
  wire        csr_hit, illegal_instr, arr_rd, arr_wr, arr_tag_sel, arr_bank;
  int         n_errors = 0;
  int         checks_done = 0;
  int         cyc = 0;
  always #12.5 clk = ~clk;
  icache_diag_data_regs #(.CHECK_MODE(0), .WAYS(4))
    icache_diag_data_regs_inst (
    .clk, .rstn, .debug_mode, .csr_read, .csr_write, .csr_addr, .csr_wdata,
    .csr_rdata, .csr_hit, .illegal_instr, .array_sel, .way_sel, .index_sel,
    .arr_rd, .arr_wr, .arr_tag_sel, .arr_way, .arr_index, .arr_bank,
    .arr_wdata, .arr_wcheck, .arr_rdata, .arr_rcheck, .lru_victim_way);
  icache_array_model icache_array_model_inst (.clk, .arr_rd, .arr_wr,
    .arr_tag_sel, .arr_way, .arr_index, .arr_wdata, .arr_wcheck,
    .arr_rdata, .arr_rcheck);
  task chk(input string nm, input [71:0] seen, input [71:0] exp);
  begin
    checks_done++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  end
  endtask
  task acc(input w, input [11:0] a, input [31:0] d);
  begin
    @(posedge clk);
    #1;
    {csr_read, csr_write, csr_addr, csr_wdata} = {!w, w, a, d};
    #20;
    {q, ill} = {csr_rdata, illegal_instr};
    @(posedge clk);
    #1;
    {csr_read, csr_write} = 2'b00;
  end
  endtask
  task wr(input [11:0] a, input [31:0] d);
    acc(1'b1, a, d);
  endtask
  task rc(input string nm, input [11:0] a, input [31:0] e);
  begin
    acc(1'b0, a, 32'h0);
    chk(nm, q, e);
  end
  endtask
  task results;
  begin
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  end
  endtask
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 1000)
    begin
      n_errors++;
      results;
    end
  end
  initial
  begin
    repeat (16) @(posedge clk);
    #1;
    rstn = 1'b1;
    rc("low reset", 12'h7c9, 32'h0);
    rc("check reset", 12'h7ca, 32'h0);
    rc("high reset", 12'h7cc, 32'h0);
    wr(12'h7c9, 32'hffffffff);
    rc("low rw", 12'h7c9, 32'hffffffff);
    wr(12'h7cc, 32'h12345678);
    rc("high rw", 12'h7cc, 32'h12345678);
    wr(12'h7ca, 32'hffffffff);
    rc("parity data mask", 12'h7ca, 32'hf);
    array_sel = 1'b1;
    rc("parity tag mask", 12'h7ca, 32'h1);
    debug_mode = 1'b0;
    wr(12'h7c9, 32'h0);
    chk("denied write", ill, 1'b1);
    rc("denied read", 12'h7c9, 32'h0);
    debug_mode = 1'b1;
    rc("low kept", 12'h7c9, 32'hffffffff);
    $display("test access done");
    {array_sel, way_sel, index_sel} = {1'b0, 2'h2, 14'h0008};
    wr(12'h7c9, 32'h11223344);
    wr(12'h7cc, 32'h55667788);
    wr(12'h7ca, 32'h0000000a);
    wr(12'h7cb, 32'h1);
    @(posedge clk);
    #1;
    chk("array data", icache_array_model_inst.mem[5'h09],
      {7'h0a, 32'h55667788, 32'h11223344});
    chk("bank", arr_bank, 1'b1);
    wr(12'h7c9, 32'h0);
    wr(12'h7cb, 32'h0000fffe);
    @(posedge clk);
    #1;
    chk("no store", icache_array_model_inst.mem[5'h09],
      {7'h0a, 32'h55667788, 32'h11223344});
    wr(12'h7cc, 32'h0);
    wr(12'h7ca, 32'h0);
    rc("go read", 12'h7cb, 32'h0);
    rc("high load", 12'h7cc, 32'h55667788);
    rc("go read", 12'h7cb, 32'h0);
    rc("low load", 12'h7c9, 32'h11223344);
    rc("check load", 12'h7ca, 32'h0000000a);
    $display("test data done");
    {array_sel, way_sel, index_sel} = {1'b1, 2'h3, 14'h0010};
    wr(12'h7c9, 32'h055e6d57);
    wr(12'h7ca, 32'hffffffff);
    wr(12'h7cb, 32'h1);
    @(posedge clk);
    #1;
    chk("array tag", icache_array_model_inst.mem[5'h1e],
      {7'h01, 32'h55667788, 32'h055e6d57});
    wr(12'h7c9, 32'h0);
    rc("go read", 12'h7cb, 32'h0);
    rc("tag load", 12'h7c9, 32'h055e6851);
    chk("victim way", lru_victim_way, 2'h3);
    rc("tag check", 12'h7ca, 32'h1);
    $display("test tag done");
    results;
  end
endmodule // icache_diag_data_regs_tb
bind icache_diag_data_regs icache_diag_props #(.INDEX_W(INDEX_W))
  icache_diag_props_inst (.clk, .rstn, .debug_mode, .csr_read, .csr_write,
  .csr_addr, .csr_wdata, .csr_rdata, .csr_hit, .illegal_instr, .arr_rd,
  .arr_wr, .arr_tag_sel, .arr_index, .arr_bank, .arr_rdata);

// ===== verif/icache_diag_props.sv
/* Assertions on the ports of the diagnostic data registers.
   Assumes a bind to the top module and a synchronous active-low reset. */
`timescale 1ns/1ps
module icache_diag_props
#(
  parameter INDEX_W = 14
)
(
  input wire               clk,
  input wire               rstn,
  input wire               debug_mode,
  input wire               csr_read,
  input wire               csr_write,
  input wire [11:0]        csr_addr,
  input wire [31:0]        csr_wdata,
  input wire [31:0]        csr_rdata,
  input wire               csr_hit,
  input wire               illegal_instr,
  input wire               arr_rd,
  input wire               arr_wr,
  input wire               arr_tag_sel,
  input wire [INDEX_W-1:0] arr_index,
  input wire               arr_bank,
  input wire [63:0]        arr_rdata
);
  wire acc = csr_read | csr_write;
  wire go = debug_mode && csr_addr == 12'h7cb;
  wire rd_lo = csr_read && !csr_write && debug_mode && csr_addr == 12'h7c9;
  wire rd_hi = csr_read && !csr_write && debug_mode && csr_addr == 12'h7cc;
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  a_illegal_access: assert property (
    illegal_instr == (acc && csr_hit && !debug_mode))
    else $error("illegal flag wrong");
  a_denied_rdata: assert property (
    csr_read && !debug_mode |-> csr_rdata == 32'h0)
    else $error("denied read returned data");
  a_go_reads_zero: assert property (
    csr_read && csr_addr == 12'h7cb |-> csr_rdata == 32'h0)
    else $error("go register read not zero");
  a_go_read_start: assert property (
    csr_read && go |=> arr_rd) else $error("go read missed");
  a_go_write_start: assert property (
    csr_write && go && csr_wdata[0] |=> arr_wr)
    else $error("go write missed");
  a_bank_index: assert property (
    arr_bank == arr_index[3]) else $error("bank select wrong");
  a_low_load: assert property (
    arr_rd && !arr_tag_sel ##1 rd_lo |-> csr_rdata == $past(arr_rdata[31:0]))
    else $error("low word load wrong");
  a_high_load: assert property (
    arr_rd && !arr_tag_sel ##1 rd_hi |-> csr_rdata == $past(arr_rdata[63:32]))
    else $error("high word load wrong");
  a_tag_load: assert property (
    arr_rd && arr_tag_sel ##1 rd_lo |->
      csr_rdata[31:11] == $past(arr_rdata[31:11]))
    else $error("tag load wrong");
  a_valid_load: assert property (
    arr_rd && arr_tag_sel ##1 rd_lo |-> csr_rdata[0] == $past(arr_rdata[0]))
    else $error("valid bit load wrong");
  a_check_reserved: assert property (
    csr_read && csr_addr == 12'h7ca |-> csr_rdata[31:7] == 25'h0)
    else $error("reserved check bits set");
endmodule // icache_diag_props
